// File: rtl/adc_i2c_map.svh
// constants for the two-wire converter slave sequencer
`ifndef ADC_I2C_MAP_SVH
`define ADC_I2C_MAP_SVH
// slave address, value arbitrary
`define SLAVE_ADDR      7'h2a
// upper five bits of the high-speed master code
`define HS_CODE_HI      5'h01
`define SETUP_RESET     8'h80
`define CONFIG_RESET    8'h01
`define TRACK_CYC       4'h2
`define CONV_CYC        4'h8
`define RAM_DEPTH       12
`define REF_PIN_CH      4'h3
`define SCAN_SINGLE     2'h3
`define OSC_PERIOD_NS   125
`define STRETCH_MAX_NS  7600
`define STRETCH_MAX_CYC (`STRETCH_MAX_NS / `OSC_PERIOD_NS)
`endif

// File: rtl/adc_i2c_pkg.sv
// types shared by the converter slave sequencer
package adc_i2c_pkg;
  typedef struct packed {
    logic       reg_bit;
    logic [2:0] sel;
    logic       clk_sel;
    logic       polarity_select;
    logic       cfg_keep;
    logic       dont_care;
  } setup_s;

  typedef struct packed {
    logic       reg_bit;
    logic [1:0] scan;
    logic [3:0] chan_sel;
    logic       input_mode_select;
  } config_s;

  typedef enum logic [7:0] {
    B_IDLE  = 8'h01,
    B_ADDR  = 8'h02,
    B_ACKA  = 8'h04,
    B_WRITE = 8'h08,
    B_ACKW  = 8'h10,
    B_CONV  = 8'h20,
    B_READ  = 8'h40,
    B_MACK  = 8'h80
  } bus_state_e;

  typedef enum logic [2:0] {
    C_IDLE  = 3'h1,
    C_TRACK = 3'h2,
    C_CONV  = 3'h4
  } conv_state_e;
endpackage : adc_i2c_pkg

// File: rtl/adc_i2c_slave_sequencer.sv
// two-wire slave front end and internal-clock conversion sequencer
// Overview of operation
// - single-ended: result is selected input minus ground
// - pseudo-differential: result is plus input minus minus input of chosen pair
// - unipolar: negative difference gives code zero
// - pseudo-differential: polarity bit picks straight binary or two's complement
// - single-ended always unipolar, polarity bit ignored
// - nine clocks per byte; sda change while scl high is start or stop
// - ack is sda low through ninth high phase; nack leaves sda released
// - idle device waits for start plus own address; last bit is direction
// - own address is acknowledged by holding sda low one clock
// - fast timing at reset; high-speed code is nacked then high-speed set
// - stop returns to fast timing; repeated start keeps current timing
// - written byte with msb set is setup, otherwise configuration
// - one or two written bytes in any order, each acknowledged
// - read: master acks to continue; on nack device releases sda
// - setup clock bit set skips conversion and reads back stored results; internal clock conversion after reset
// - tracking starts at ninth falling edge; sample two oscillator cycles later
// - scl held low until all conversions finish, at most 7.6us per channel
// - each result of a scan goes to the next result memory slot
// - results read first in first out; pointer wraps after the last
// - shared reference pin skipped in scans when reference use bit set
`timescale 1ns/10ps
`default_nettype none
`include "adc_i2c_map.svh"
module adc_i2c_slave_sequencer (
  // system clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  resetn_i,
  // internal conversion oscillator
  input  wire logic                  conv_clk_i,
  // two-wire bus, open drain
  input  wire logic                  scl_i,
  output logic                       scl_o,
  output logic                       scl_oe_o,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_o,
  // converter front end, conv_clk_i domain
  output logic [3:0]                 mux_pos_o,
  output logic [3:0]                 mux_neg_o,
  output logic                       neg_gnd_o,
  output logic                       th_hold_o,
  input  wire logic [7:0]            vin_pos_i,
  input  wire logic [7:0]            vin_neg_i,
  // status
  output var adc_i2c_pkg::setup_s    setup_o,
  output var adc_i2c_pkg::config_s   config_o,
  output logic                       hs_mode_o
);
  logic [1:0]               rsync_r;
  logic [1:0]               csync_r;
  logic                     rst_n;
  logic                     crst_n;
  logic [2:0]               scl_sy_r;
  logic [2:0]               sda_sy_r;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start_evt;
  logic                     stop_evt;
  adc_i2c_pkg::bus_state_e  st_r;
  logic [3:0]               bcnt_r;
  logic [7:0]               sh_r;
  logic [7:0]               tx_r;
  logic                     rw_r;
  logic                     hs_code_r;
  logic                     mack_r;
  logic [3:0]               rd_ptr_r;
  logic [3:0]               ptr_nxt;
  logic                     wr_evt;
  logic                     req_tgl_r;
  logic [2:0]               req_sy_r;
  logic                     req_evt;
  logic                     done_tgl_r;
  logic [2:0]               done_sy_r;
  logic                     done_evt;
  adc_i2c_pkg::conv_state_e cst_r;
  logic [3:0]               ccnt_r;
  logic [3:0]               ch_r;
  logic [3:0]               ch_nxt;
  logic [3:0]               last_r;
  logic                     multi_r;
  logic                     skip_r;
  logic                     sgl_r;
  logic                     bip_r;
  logic [3:0]               wr_r;
  logic [3:0]               res_cnt_r;
  logic [7:0]               code_r;
  logic [8:0]               diff;
  logic [7:0]               ram [`RAM_DEPTH];

  // reset release, one synchroniser per domain
  always_ff @(posedge mclk_i or negedge resetn_i)
    if (!resetn_i)
      rsync_r <= 2'h0;
    else
      rsync_r <= {rsync_r[0], 1'b1};
  always_ff @(posedge conv_clk_i or negedge resetn_i)
    if (!resetn_i)
      csync_r <= 2'h0;
    else
      csync_r <= {csync_r[0], 1'b1};
  assign rst_n  = rsync_r[1];
  assign crst_n = csync_r[1];

  // bus pins: two flops, then a history flop for edges
  always_ff @(posedge mclk_i or negedge rst_n)
    if (!rst_n)
    begin
      scl_sy_r <= 3'h7;
      sda_sy_r <= 3'h7;
    end
    else
    begin
      scl_sy_r <= {scl_sy_r[1:0], scl_i};
      sda_sy_r <= {sda_sy_r[1:0], sda_i};
    end
  assign scl_rise  = scl_sy_r[1] & ~scl_sy_r[2];
  assign scl_fall  = ~scl_sy_r[1] & scl_sy_r[2];
  assign start_evt = scl_sy_r[1] & scl_sy_r[2] & ~sda_sy_r[1] & sda_sy_r[2];
  assign stop_evt  = scl_sy_r[1] & scl_sy_r[2] & sda_sy_r[1] & ~sda_sy_r[2];
  assign wr_evt    = (st_r == adc_i2c_pkg::B_WRITE) && scl_fall && (bcnt_r == 4'h8);
  assign ptr_nxt   = (rd_ptr_r + 4'h1 >= res_cnt_r) ? 4'h0 : rd_ptr_r + 4'h1;
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;

  // bus sequencer
  always_ff @(posedge mclk_i or negedge rst_n)
    if (!rst_n)
    begin
      st_r      <= adc_i2c_pkg::B_IDLE;
      bcnt_r    <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      rw_r      <= 1'b0;
      hs_code_r <= 1'b0;
      mack_r    <= 1'b0;
      rd_ptr_r  <= 4'h0;
      sda_oe_o  <= 1'b0;
      scl_oe_o  <= 1'b0;
      req_tgl_r <= 1'b0;
    end
    else if (start_evt)
    begin
      st_r     <= adc_i2c_pkg::B_ADDR;
      bcnt_r   <= 4'h0;
      sda_oe_o <= 1'b0;
    end
    else if (stop_evt)
    begin
      st_r     <= adc_i2c_pkg::B_IDLE;
      sda_oe_o <= 1'b0;
    end
    else
      case (st_r)
        adc_i2c_pkg::B_ADDR, adc_i2c_pkg::B_WRITE:
          if (scl_rise && bcnt_r != 4'h8)
          begin
            sh_r   <= {sh_r[6:0], sda_sy_r[1]};
            bcnt_r <= bcnt_r + 4'h1;
          end
          else if (scl_fall && bcnt_r == 4'h8)
          begin
            if (st_r == adc_i2c_pkg::B_WRITE)
            begin
              sda_oe_o <= 1'b1;
              st_r     <= adc_i2c_pkg::B_ACKW;
            end
            else if (sh_r[7:1] == `SLAVE_ADDR)
            begin
              sda_oe_o  <= 1'b1;
              rw_r      <= sh_r[0];
              hs_code_r <= 1'b0;
              rd_ptr_r  <= 4'h0;
              st_r      <= adc_i2c_pkg::B_ACKA;
            end
            else if (sh_r[7:3] == `HS_CODE_HI)
            begin
              hs_code_r <= 1'b1;
              st_r      <= adc_i2c_pkg::B_ACKA;
            end
            else
              st_r <= adc_i2c_pkg::B_IDLE;
          end
        adc_i2c_pkg::B_ACKA:
          if (scl_fall)
          begin
            sda_oe_o <= 1'b0;
            bcnt_r   <= 4'h0;
            if (hs_code_r)
              st_r <= adc_i2c_pkg::B_IDLE;
            else if (!rw_r)
              st_r <= adc_i2c_pkg::B_WRITE;
            else if (!setup_o.clk_sel)
            begin
              scl_oe_o  <= 1'b1;
              req_tgl_r <= ~req_tgl_r;
              st_r      <= adc_i2c_pkg::B_CONV;
            end
            else
            begin
              tx_r     <= ram[rd_ptr_r];
              sda_oe_o <= ~ram[rd_ptr_r][7];
              rd_ptr_r <= ptr_nxt;
              st_r     <= adc_i2c_pkg::B_READ;
            end
          end
        adc_i2c_pkg::B_ACKW:
          if (scl_fall)
          begin
            sda_oe_o <= 1'b0;
            bcnt_r   <= 4'h0;
            st_r     <= adc_i2c_pkg::B_WRITE;
          end
        adc_i2c_pkg::B_CONV:
          if (done_evt)
          begin
            // first bit set up while scl is still held low; scl freed a cycle later
            tx_r     <= ram[rd_ptr_r];
            sda_oe_o <= ~ram[rd_ptr_r][7];
            rd_ptr_r <= ptr_nxt;
            st_r     <= adc_i2c_pkg::B_READ;
          end
        adc_i2c_pkg::B_READ:
          if (scl_oe_o)
            scl_oe_o <= 1'b0;
          else if (scl_fall)
          begin
            if (bcnt_r == 4'h7)
            begin
              sda_oe_o <= 1'b0;
              st_r     <= adc_i2c_pkg::B_MACK;
            end
            else
            begin
              tx_r     <= {tx_r[6:0], 1'b0};
              sda_oe_o <= ~tx_r[6];
              bcnt_r   <= bcnt_r + 4'h1;
            end
          end
        adc_i2c_pkg::B_MACK:
          if (scl_rise)
            mack_r <= ~sda_sy_r[1];
          else if (scl_fall)
          begin
            bcnt_r <= 4'h0;
            if (mack_r)
            begin
              tx_r     <= ram[rd_ptr_r];
              sda_oe_o <= ~ram[rd_ptr_r][7];
              rd_ptr_r <= ptr_nxt;
              st_r     <= adc_i2c_pkg::B_READ;
            end
            else
              st_r <= adc_i2c_pkg::B_IDLE;
          end
        adc_i2c_pkg::B_IDLE:
          st_r <= adc_i2c_pkg::B_IDLE;
        default:
          st_r <= adc_i2c_pkg::B_IDLE;
      endcase

  // bus timing mode
  always_ff @(posedge mclk_i or negedge rst_n)
    if (!rst_n)
      hs_mode_o <= 1'b0;
    else if (stop_evt)
      hs_mode_o <= 1'b0;
    else if (st_r == adc_i2c_pkg::B_ACKA && scl_fall && hs_code_r)
      hs_mode_o <= 1'b1;

  // setup and configuration bytes
  always_ff @(posedge mclk_i or negedge rst_n)
    if (!rst_n)
    begin
      setup_o  <= `SETUP_RESET;
      config_o <= `CONFIG_RESET;
    end
    else if (wr_evt)
    begin
      if (sh_r[7])
      begin
        setup_o <= sh_r;
        if (!sh_r[1])
          config_o <= `CONFIG_RESET;
      end
      else
        config_o <= sh_r;
    end

  // request into oscillator domain, done back; settings are quiet meanwhile
  always_ff @(posedge conv_clk_i or negedge crst_n)
    if (!crst_n)
      req_sy_r <= 3'h0;
    else
      req_sy_r <= {req_sy_r[1:0], req_tgl_r};
  always_ff @(posedge mclk_i or negedge rst_n)
    if (!rst_n)
      done_sy_r <= 3'h0;
    else
      done_sy_r <= {done_sy_r[1:0], done_tgl_r};
  assign req_evt  = req_sy_r[1] ^ req_sy_r[2];
  assign done_evt = done_sy_r[1] ^ done_sy_r[2];

  // next scan channel, stepping over the shared reference pin
  assign ch_nxt = (skip_r && ch_r + 4'h1 == `REF_PIN_CH) ? ch_r + 4'h2 : ch_r + 4'h1;
  assign diff   = {1'b0, vin_pos_i} - (sgl_r ? 9'h000 : {1'b0, vin_neg_i});
  assign mux_pos_o = ch_r;
  assign mux_neg_o = ch_r ^ 4'h1;
  assign neg_gnd_o = sgl_r;

  // conversion sequencer on the internal oscillator
  always_ff @(posedge conv_clk_i or negedge crst_n)
    if (!crst_n)
    begin
      cst_r      <= adc_i2c_pkg::C_IDLE;
      ccnt_r     <= 4'h0;
      ch_r       <= 4'h0;
      last_r     <= 4'h0;
      multi_r    <= 1'b0;
      skip_r     <= 1'b0;
      sgl_r      <= 1'b1;
      bip_r      <= 1'b0;
      wr_r       <= 4'h0;
      res_cnt_r  <= 4'h0;
      code_r     <= 8'h00;
      th_hold_o  <= 1'b0;
      done_tgl_r <= 1'b0;
    end
    else
      case (cst_r)
        adc_i2c_pkg::C_IDLE:
          if (req_evt)
          begin
            multi_r <= config_o.scan != `SCAN_SINGLE;
            ch_r    <= (config_o.scan != `SCAN_SINGLE) ? 4'h0 : config_o.chan_sel;
            last_r  <= config_o.chan_sel;
            skip_r  <= setup_o.sel[1];
            sgl_r   <= config_o.input_mode_select;
            bip_r   <= setup_o.polarity_select;
            wr_r    <= 4'h0;
            ccnt_r  <= `TRACK_CYC;
            cst_r   <= adc_i2c_pkg::C_TRACK;
          end
        adc_i2c_pkg::C_TRACK:
          if (ccnt_r == 4'h1)
          begin
            th_hold_o <= 1'b1;
            ccnt_r    <= `CONV_CYC;
            cst_r     <= adc_i2c_pkg::C_CONV;
            if (sgl_r || !bip_r)
              code_r <= diff[8] ? 8'h00 : diff[7:0];
            else if ($signed(diff) > $signed(9'h07f))
              code_r <= 8'h7f;
            else if ($signed(diff) < $signed(9'h180))
              code_r <= 8'h80;
            else
              code_r <= diff[7:0];
          end
          else
            ccnt_r <= ccnt_r - 4'h1;
        adc_i2c_pkg::C_CONV:
          if (ccnt_r == 4'h1)
          begin
            th_hold_o <= 1'b0;
            wr_r      <= wr_r + 4'h1;
            if (!multi_r || ch_nxt > last_r)
            begin
              res_cnt_r  <= wr_r + 4'h1;
              done_tgl_r <= ~done_tgl_r;
              cst_r      <= adc_i2c_pkg::C_IDLE;
            end
            else
            begin
              ch_r   <= ch_nxt;
              ccnt_r <= `TRACK_CYC;
              cst_r  <= adc_i2c_pkg::C_TRACK;
            end
          end
          else
            ccnt_r <= ccnt_r - 4'h1;
        default:
          cst_r <= adc_i2c_pkg::C_IDLE;
      endcase

  // result memory has no reset; contents unknown until first scan
  always_ff @(posedge conv_clk_i)
    if (cst_r == adc_i2c_pkg::C_CONV && ccnt_r == 4'h1)
      ram[wr_r] <= code_r;

  a_addr_ack: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (st_r == adc_i2c_pkg::B_ADDR && scl_fall && bcnt_r == 4'h8 && sh_r[7:1] == `SLAVE_ADDR
     && !start_evt && !stop_evt) |=> sda_oe_o && st_r == adc_i2c_pkg::B_ACKA)
    else $error("own address not acknowledged");
  a_hs_nack: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (st_r == adc_i2c_pkg::B_ACKA && hs_code_r) |-> !sda_oe_o)
    else $error("high-speed code was acknowledged");
  a_stop_fast: assert property (@(posedge mclk_i) disable iff (!rst_n)
    stop_evt |=> !hs_mode_o)
    else $error("stop left high-speed timing");
  a_restart_keep: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (start_evt && hs_mode_o) |=> hs_mode_o)
    else $error("repeated start dropped timing mode");
  a_setup_route: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (wr_evt && sh_r[7]) |=> setup_o == $past(sh_r))
    else $error("setup byte not stored");
  a_stretch_hold: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (st_r == adc_i2c_pkg::B_CONV) |-> scl_oe_o)
    else $error("scl released during conversion");
  a_msb_first: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (st_r == adc_i2c_pkg::B_READ) |-> sda_oe_o == ~tx_r[7])
    else $error("sda not msb of shifter");
  a_ptr_wrap: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (st_r == adc_i2c_pkg::B_MACK && scl_fall && mack_r && !start_evt && !stop_evt
     && rd_ptr_r + 4'h1 >= res_cnt_r) |=> rd_ptr_r == 4'h0)
    else $error("read pointer did not wrap");
  a_track_delay: assert property (@(posedge conv_clk_i) disable iff (!crst_n)
    (cst_r == adc_i2c_pkg::C_IDLE && req_evt) |=> !th_hold_o ##1 !th_hold_o ##1 th_hold_o)
    else $error("sample not two cycles after tracking");
  a_uni_clamp: assert property (@(posedge conv_clk_i) disable iff (!crst_n)
    (cst_r == adc_i2c_pkg::C_TRACK && ccnt_r == 4'h1 && !bip_r && diff[8]) |=> code_r == 8'h00)
    else $error("negative unipolar input not clamped");
  a_single_ended: assert property (@(posedge conv_clk_i) disable iff (!crst_n)
    (cst_r == adc_i2c_pkg::C_TRACK && ccnt_r == 4'h1 && sgl_r) |=> code_r == $past(vin_pos_i))
    else $error("single-ended result not input minus ground");
  localparam int CHAN_MAX_CYC = `STRETCH_MAX_CYC;
  a_chan_budget: assert property (@(posedge conv_clk_i) disable iff (!crst_n)
    (cst_r == adc_i2c_pkg::C_TRACK && $past(cst_r) != adc_i2c_pkg::C_TRACK)
    |-> ##[1:CHAN_MAX_CYC] (cst_r == adc_i2c_pkg::C_CONV && ccnt_r == 4'h1))
    else $error("per channel time over stretch limit");
  c_hs_entry: cover property (@(posedge mclk_i) disable iff (!rst_n) $rose(hs_mode_o));
  c_write: cover property (@(posedge mclk_i) disable iff (!rst_n) wr_evt && !sh_r[7]);
  c_conv_done: cover property (@(posedge mclk_i) disable iff (!rst_n) done_evt);
  c_wrap: cover property (@(posedge mclk_i) disable iff (!rst_n)
    st_r == adc_i2c_pkg::B_MACK && scl_fall && mack_r && ptr_nxt == 4'h0);
endmodule : adc_i2c_slave_sequencer
`default_nettype wire

// File: verif/i2c_master_model.sv
// two-wire bus master model facing the converter slave
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
  // clock
  input  wire logic       mclk_i,
  // wire levels
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  // open-drain pulls, high pulls the line low
  output logic            scl_oe_o,
  output logic            sda_oe_o,
  // one result per byte: read data or ack flag
  output logic            got_tgl_o,
  output logic [7:0]      got_data_o
);
  // ten mclk per half period keeps clear of the 4-cycle minimum
  localparam int HALF = 10;

  initial
  begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    got_tgl_o = 1'b0;
    got_data_o = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick

  // releases scl and waits out stretching, bounded
  task automatic rise();
    int k;
    k = 0;
    scl_oe_o = 1'b0;
    while (scl_i !== 1'b1 && k < 3000)
    begin
      tick(1);
      k++;
    end
    tick(HALF / 2);
  endtask : rise

  task automatic bit_cyc(input logic d, output logic s);
    sda_oe_o = ~d;
    tick(HALF);
    rise();
    s = sda_i;
    tick(HALF / 2);
    scl_oe_o = 1'b1;
    tick(2);
  endtask : bit_cyc

  task automatic xfer(input logic [7:0] d, input logic rd, input logic ack);
    logic [7:0] r;
    logic       s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cyc(rd | d[i], s);
      r[i] = s;
    end
    bit_cyc(rd ? ~ack : 1'b1, s);
    got_data_o = rd ? r : {7'h00, ~s};
    got_tgl_o = ~got_tgl_o;
  endtask : xfer

  task automatic start();
    sda_oe_o = 1'b0;
    tick(HALF);
    rise();
    sda_oe_o = 1'b1;
    tick(HALF);
    scl_oe_o = 1'b1;
    tick(2);
  endtask : start

  task automatic stop();
    sda_oe_o = 1'b1;
    tick(HALF);
    rise();
    sda_oe_o = 1'b0;
    tick(HALF);
  endtask : stop
endmodule : i2c_master_model
`default_nettype wire

// File: verif/adc_i2c_slave_sequencer_tb.sv
// self-checking bench for the converter slave sequencer
`timescale 1ns/10ps
`default_nettype none
`include "adc_i2c_map.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module adc_i2c_slave_sequencer_tb;
  logic                 mclk, conv_clk, resetn, m_scl, m_sda, got_tgl;
  logic                 scl_oe, sda_oe, neg_gnd, hs_mode;
  logic [3:0]           mux_pos, mux_neg;
  logic [7:0]           got_data, vin_pos, vin_neg, e;
  logic [7:0]           ain [16];
  logic [7:0]           exp_q [$];
  adc_i2c_pkg::setup_s  setup;
  adc_i2c_pkg::config_s cfg;
  int                   num_errors = 0;
  int                   comparisons = 0;
  // pull-ups on both lines
  wire logic            scl_w = ~(m_scl | scl_oe);
  wire logic            sda_w = ~(m_sda | sda_oe);

  adc_i2c_slave_sequencer u_dut (
    .mclk_i(mclk), .resetn_i(resetn), .conv_clk_i(conv_clk),
    .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
    .mux_pos_o(mux_pos), .mux_neg_o(mux_neg), .neg_gnd_o(neg_gnd),
    .th_hold_o(), .vin_pos_i(vin_pos), .vin_neg_i(vin_neg),
    .setup_o(setup), .config_o(cfg), .hs_mode_o(hs_mode)
  );

  i2c_master_model u_master (
    .mclk_i(mclk), .scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl),
    .sda_oe_o(m_sda), .got_tgl_o(got_tgl), .got_data_o(got_data)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // phase unrelated to mclk
  initial
  begin
    conv_clk = 1'b0;
    #7;
    forever #62.5 conv_clk = ~conv_clk;
  end

  // analog front end, converter domain
  always @(posedge conv_clk)
  begin
    vin_pos <= #1 ain[mux_pos];
    vin_neg <= #1 neg_gnd ? 8'h00 : ain[mux_neg];
  end

  // result watcher
  always @(got_tgl)
  begin
    if ($time > 0)
    begin
      if (exp_q.size() == 0)
      begin
        num_errors++;
        $display("[ERR] %0t unexpected byte", $time);
      end
      else
      begin
        e = exp_q.pop_front();
        `CHK(got_data, e)
      end
    end
  end

  function automatic logic [7:0] code(input int ch, input logic sgl, input logic bip);
    int d;
    d = sgl ? int'(ain[ch]) : int'(ain[ch]) - int'(ain[ch ^ 1]);
    if (sgl | ~bip)
      return (d < 0) ? 8'h00 : 8'(d);
    return 8'((d > 127) ? 127 : (d < -128) ? -128 : d);
  endfunction : code

  task automatic wr(input logic [7:0] b, input logic ack);
    exp_q.push_back({7'h00, ack});
    u_master.xfer(b, 1'b0, 1'b0);
  endtask : wr

  task automatic scan_rd(input logic sgl, input logic bip, input logic skip,
                         input logic [1:0] scn, input logic [3:0] ch, input int extra);
    logic [7:0] res [$];
    logic [7:0] stp;
    int         n;
    stp = {1'b1, 1'b0, skip, 1'b0, 1'b0, bip, 1'b1, 1'b0};
    u_master.start();
    wr({`SLAVE_ADDR, 1'b0}, 1'b1);
    wr(stp, 1'b1);
    wr({1'b0, scn, ch, sgl}, 1'b1);
    `CHK({setup, cfg}, {stp, 1'b0, scn, ch, sgl})
    u_master.start();
    wr({`SLAVE_ADDR, 1'b1}, 1'b1);
    for (int c = (scn == `SCAN_SINGLE) ? int'(ch) : 0; c <= int'(ch); c++)
      if (!(skip && c == `REF_PIN_CH)) res.push_back(code(c, sgl, bip));
    n = res.size() + extra;
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back(res[i % res.size()]);
      u_master.xfer(8'h00, 1'b1, i < n - 1);
    end
    u_master.stop();
  endtask : scan_rd

  task automatic print_verdict();
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  initial
  begin
    #2000000;
    num_errors++;
    print_verdict();
  end

  initial
  begin
    resetn = 1'b0;
    vin_pos = 8'h00;
    vin_neg = 8'h00;
    void'($urandom(32'h146c31dd));
    for (int i = 0; i < 16; i++)
      ain[i] = 8'($urandom);
    repeat (6) @(posedge mclk);
    #1 resetn = 1'b1;
    u_master.tick(20);
    `CHK({setup, cfg, hs_mode}, {`SETUP_RESET, `CONFIG_RESET, 1'b0})
    // foreign address is nacked and ignored, then the bus is stopped
    u_master.start();
    wr({`SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b0);
    u_master.stop();
    // all four coding modes, each with fresh inputs
    for (int m = 0; m < 4; m++)
    begin
      for (int i = 0; i < 16; i++)
        ain[i] = 8'($urandom);
      scan_rd(m % 3 == 0, m >= 2, m[0], 2'h0, 4'(5 + m), 2);
    end
    scan_rd(1'b0, 1'b1, 1'b0, `SCAN_SINGLE, 4'h2, 1);
    scan_rd(1'b1, 1'b0, 1'b0, 2'h1, 4'hb, 1);
    // clock bit set: no conversion, last results played back from the start
    u_master.start();
    wr({`SLAVE_ADDR, 1'b0}, 1'b1);
    wr(8'h8a, 1'b1);
    `CHK(setup.clk_sel, 1'b1)
    u_master.start();
    wr({`SLAVE_ADDR, 1'b1}, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      exp_q.push_back(code(i, 1'b1, 1'b0));
      u_master.xfer(8'h00, 1'b1, i == 0);
    end
    // config first, then setup that restores config defaults
    u_master.start();
    wr({`SLAVE_ADDR, 1'b0}, 1'b1);
    wr(8'h1a, 1'b1);
    wr(8'h80, 1'b1);
    `CHK(cfg, `CONFIG_RESET)
    // high-speed code: nack, switch, repeated start keeps timing
    u_master.start();
    wr(8'h0d, 1'b0);
    u_master.tick(8);
    `CHK(hs_mode, 1'b1)
    u_master.start();
    wr({`SLAVE_ADDR, 1'b0}, 1'b1);
    wr(8'h12, 1'b1);
    `CHK({hs_mode, cfg}, {1'b1, 8'h12})
    u_master.stop();
    u_master.tick(8);
    `CHK(hs_mode, 1'b0)
    print_verdict();
  end
endmodule : adc_i2c_slave_sequencer_tb
`default_nettype wire
